// [sram_host_map.svh]
`ifndef SRAM_HOST_MAP_SVH
`define SRAM_HOST_MAP_SVH

// ****************************************************
// build-time grade and clock
// ****************************************************
`define SRAM_GRADE_NS  55
`define CLK_PERIOD_NS  20
`define ADDR_W         17
`define DATA_W         9
`define WORDS          131072
`define SYNC_STAGES    2
`define WAIT_W         18

`define GRADE_PICK(a, b, c) ((`SRAM_GRADE_NS == 55) ? (a) : (`SRAM_GRADE_NS == 70) ? (b) : (c))
`define MAX2(a, b) (((a) > (b)) ? (a) : (b))
`define CYC_MIN(ns) `MAX2(1, (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

// ****************************************************
// device timing in ns, per grade; recovery time in ms
// ****************************************************
`define T_RC_NS    `GRADE_PICK(55, 70, 100)
`define T_AA_NS    `GRADE_PICK(55, 70, 100)
`define T_CO_NS    `GRADE_PICK(55, 70, 100)
`define T_OE_NS    `GRADE_PICK(30, 40, 50)
`define T_HZ_NS    `GRADE_PICK(25, 25, 35)
`define T_OHZ_NS   `GRADE_PICK(25, 25, 35)
`define T_WC_NS    `GRADE_PICK(55, 70, 100)
`define T_AW_NS    `GRADE_PICK(50, 60, 70)
`define T_WP_NS    `GRADE_PICK(40, 50, 60)
`define T_DW_NS    `GRADE_PICK(25, 30, 40)
`define T_DH_NS    0
`define T_CDRS_NS  0
`define T_R_MS     5

// ****************************************************
// derived cycle counts
// ****************************************************
`define ACC_CYC    `CYC_MIN(`MAX2(`MAX2(`T_AA_NS, `T_CO_NS), `MAX2(`T_OE_NS, `T_RC_NS)))
`define WP_CYC     `CYC_MIN(`MAX2(`MAX2(`T_WP_NS, `T_AW_NS), `MAX2(`T_DW_NS, `T_WC_NS)))
`define TURN_CYC   `CYC_MIN(`MAX2(`T_HZ_NS, `T_OHZ_NS))
`define REC_CYC    ((`T_R_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// [sram_host_pkg.sv]
`include "sram_host_map.svh"

package sram_host_pkg;

   typedef struct packed {
      logic               write;
      logic [`ADDR_W-1:0] word_address;
      logic [`DATA_W-1:0] wdata;
   } req_s;

   typedef struct packed {
      logic [`ADDR_W-1:0] word_address;
      logic               chip_select_active_low;
      logic               chip_select_active_high;
      logic               output_enable_n;
      logic               write_enable_n;
      logic [`DATA_W-1:0] data_pins_out;
      logic               data_pins_oe;
   } pins_s;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_WSETUP  = 3'b001,
      ST_WPULSE  = 3'b010,
      ST_WEND    = 3'b011,
      ST_RACCESS = 3'b100,
      ST_TURN    = 3'b101,
      ST_RETAIN  = 3'b110,
      ST_RECOVER = 3'b111
   } state_e;

endpackage

// [pin_sync.sv]
`timescale 1ns/1ps

module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge core_clk) begin
      if (reset) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

// [sram_host.sv]
`timescale 1ns/1ps
`include "sram_host_map.svh"

// Contract
// - address 50 ns, strobe 40 ns before write end
// - data 25 ns before end, hold 0 ns
// - host never fights device output drive
// - deselect for retention, wait 5 ms after
module sram_host #(
   parameter int RECOVERY_CYCLES = `REC_CYC
) (
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   input  wire logic                  req_valid,
   input  wire sram_host_pkg::req_s   req,
   output logic                       req_ready,
   output logic [`DATA_W-1:0]         rdata,
   output logic                       rdata_valid,
   output logic                       write_done,
   input  wire logic                  retention_req,
   output sram_host_pkg::pins_s       sram_pins,
   input  wire logic [`DATA_W-1:0]    data_pins_in
);
   import sram_host_pkg::*;

   // ****************************************************
   // next state
   // ****************************************************
   state_e              state_q;
   state_e              state_d;
   logic [`WAIT_W-1:0]  wait_q;
   logic [`WAIT_W-1:0]  wait_d;
   req_s                req_q;
   req_s                cur;
   logic                accept;
   logic [`DATA_W-1:0]  dq_sync;

   assign accept = req_valid && req_ready;
   assign cur    = accept ? req : req_q;

   always_comb begin
      state_d = state_q;
      wait_d  = wait_q;
      case (state_q)
         ST_IDLE: begin
            if (accept && req.write) begin
               state_d = ST_WSETUP;
            end else if (accept) begin
               state_d = ST_RACCESS;
               wait_d  = `WAIT_W'(`ACC_CYC + `SYNC_STAGES - 1);
            end else if (retention_req) begin
               state_d = ST_RETAIN;
            end
         end
         ST_WSETUP: begin
            state_d = ST_WPULSE;
            wait_d  = `WAIT_W'(`WP_CYC - 1);
         end
         ST_WPULSE: begin
            if (wait_q == '0) begin
               state_d = ST_WEND;
            end else begin
               wait_d = wait_q - `WAIT_W'(1);
            end
         end
         ST_WEND: begin
            state_d = ST_IDLE;
         end
         ST_RACCESS: begin
            if (wait_q == '0) begin
               state_d = ST_TURN;
               wait_d  = `WAIT_W'(`TURN_CYC - 1);
            end else begin
               wait_d = wait_q - `WAIT_W'(1);
            end
         end
         ST_TURN: begin
            if (wait_q == '0) begin
               state_d = ST_IDLE;
            end else begin
               wait_d = wait_q - `WAIT_W'(1);
            end
         end
         ST_RETAIN: begin
            if (!retention_req) begin
               state_d = ST_RECOVER;
               wait_d  = `WAIT_W'(RECOVERY_CYCLES - 1);
            end
         end
         ST_RECOVER: begin
            if (wait_q == '0) begin
               state_d = ST_IDLE;
            end else begin
               wait_d = wait_q - `WAIT_W'(1);
            end
         end
         default: begin
            state_d = ST_IDLE;
            wait_d  = '0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         wait_q  <= '0;
      end else begin
         state_q <= state_d;
         wait_q  <= wait_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         req_q <= '0;
      end else if (accept) begin
         req_q <= req;
      end
   end

   // ****************************************************
   // pin drive, registered from the next state
   // ****************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sram_pins <= '{default: '0, chip_select_active_low: 1'b1,
                        output_enable_n: 1'b1, write_enable_n: 1'b1};
      end else begin
         sram_pins.word_address            <= cur.word_address;
         sram_pins.data_pins_out           <= cur.wdata;
         sram_pins.chip_select_active_low  <= 1'b1;
         sram_pins.chip_select_active_high <= 1'b0;
         sram_pins.output_enable_n         <= 1'b1;
         sram_pins.write_enable_n          <= 1'b1;
         sram_pins.data_pins_oe            <= 1'b0;
         case (state_d)
            ST_WSETUP, ST_WPULSE, ST_WEND: begin
               // oe stays high so the device never drives during a write
               sram_pins.chip_select_active_low  <= 1'b0;
               sram_pins.chip_select_active_high <= 1'b1;
               sram_pins.data_pins_oe            <= 1'b1;
               sram_pins.write_enable_n          <= (state_d != ST_WPULSE);
            end
            ST_RACCESS: begin
               sram_pins.chip_select_active_low  <= 1'b0;
               sram_pins.chip_select_active_high <= 1'b1;
               sram_pins.output_enable_n         <= 1'b0;
            end
            default: begin
               // idle, turnaround and retention keep both selects off
            end
         endcase
      end
   end

   // ****************************************************
   // read capture and user side
   // ****************************************************
   pin_sync #(
      .WIDTH (`DATA_W)
   ) u_dq_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .d        (data_pins_in),
      .q        (dq_sync)
   );

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdata       <= '0;
         rdata_valid <= 1'b0;
         write_done  <= 1'b0;
         req_ready   <= 1'b0;
      end else begin
         rdata_valid <= (state_q == ST_RACCESS) && (wait_q == '0);
         write_done  <= (state_q == ST_WEND);
         req_ready   <= (state_d == ST_IDLE) && !retention_req;
         if ((state_q == ST_RACCESS) && (wait_q == '0)) begin
            // sync delay is covered by holding oe for extra cycles
            rdata <= dq_sync;
         end
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   logic [7:0]         we_low_cnt;
   logic [7:0]         oe_high_cnt;
   logic [7:0]         oe_low_cnt;
   logic [`WAIT_W-1:0] rec_cnt;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         we_low_cnt  <= '0;
         oe_high_cnt <= 8'hff;
         oe_low_cnt  <= '0;
         rec_cnt     <= '0;
      end else begin
         we_low_cnt  <= sram_pins.write_enable_n ? 8'h00 :
                        we_low_cnt + {7'h00, (we_low_cnt != 8'hff)};
         oe_high_cnt <= !sram_pins.output_enable_n ? 8'h00 :
                        oe_high_cnt + {7'h00, (oe_high_cnt != 8'hff)};
         oe_low_cnt  <= sram_pins.output_enable_n ? 8'h00 :
                        oe_low_cnt + {7'h00, (oe_low_cnt != 8'hff)};
         rec_cnt     <= (state_q == ST_RETAIN) ? '0 : rec_cnt + `WAIT_W'(rec_cnt != '1);
      end
   end

   a_we_pulse_width: assert property (@(posedge core_clk) disable iff (reset)
      $rose(sram_pins.write_enable_n) |-> we_low_cnt >= 8'(`WP_CYC))
      else $error("write strobe shorter than required");

   a_addr_stable_wr: assert property (@(posedge core_clk) disable iff (reset)
      !sram_pins.write_enable_n |-> $stable(sram_pins.word_address)
         && !sram_pins.chip_select_active_low && sram_pins.chip_select_active_high)
      else $error("address or select moved during write strobe");

   a_data_setup_hold: assert property (@(posedge core_clk) disable iff (reset)
      $rose(sram_pins.write_enable_n) |-> sram_pins.data_pins_oe
         && $stable(sram_pins.data_pins_out) ##1 !sram_pins.data_pins_oe)
      else $error("write data not held around write end");

   a_no_contention: assert property (@(posedge core_clk) disable iff (reset)
      sram_pins.data_pins_oe |-> sram_pins.output_enable_n
         && oe_high_cnt >= 8'(`TURN_CYC))
      else $error("host drives data while device may drive");

   a_read_window: assert property (@(posedge core_clk) disable iff (reset)
      $rose(rdata_valid) |-> $past(oe_low_cnt) >= 8'(`ACC_CYC + `SYNC_STAGES - 1))
      else $error("read captured before access time plus sync");

   a_read_pulse: assert property (@(posedge core_clk) disable iff (reset)
      $fell(sram_pins.output_enable_n) |-> ##[1:8] rdata_valid)
      else $error("read data not returned in time");

   a_retain_desel: assert property (@(posedge core_clk) disable iff (reset)
      (state_q == ST_RETAIN) |=> sram_pins.chip_select_active_low
         && !sram_pins.chip_select_active_high && !req_ready)
      else $error("chip selected during retention");

   a_recover_wait: assert property (@(posedge core_clk) disable iff (reset)
      ($past(state_q) == ST_RECOVER) && (state_q == ST_IDLE)
         |-> rec_cnt >= `WAIT_W'(RECOVERY_CYCLES))
      else $error("access allowed before recovery time");

   a_turn_float: assert property (@(posedge core_clk) disable iff (reset)
      $rose(sram_pins.output_enable_n) |-> !sram_pins.data_pins_oe [*2])
      else $error("host drive before device float time");

endmodule

// [sram_model.sv]
`timescale 1ns/1ps
// ****************************************************
// behavioural ram on the far side of the pins
// ****************************************************
module sram_model #(
   parameter int ACCESS_NS = 55
) (
   input  wire sram_host_pkg::pins_s p,
   output logic [8:0]                lvl,
   output int                        viol
);
   import sram_host_pkg::*;
   logic [8:0]  mem [131072];
   logic [16:0] la;
   logic [8:0]  ld;
   logic        lrd;
   logic        wact;
   logic        valid;
   int          ans;
   int          wns;
   int          dns;
   wire logic   sel = !p.chip_select_active_low && p.chip_select_active_high;
   wire logic   rd = sel && !p.output_enable_n && p.write_enable_n;
   wire logic   wr = sel && !p.write_enable_n;

   // polled every ns, half a ns off the clock edges to stay out of their races
   initial begin
      {lvl, la, ld, lrd, wact, valid} = '0;
      {viol, ans, wns, dns} = '0;
      #0.5;
      forever begin
         ans = (p.word_address !== la || rd !== lrd) ? 0 : ans + 1;
         dns = (p.data_pins_out !== ld) ? 0 : dns + 1;
         if (wact && !wr) begin
            if (ans < 50 || wns < 40 || dns < 25) viol++;
            mem[la] = ld;
         end
         wns = wr ? wns + 1 : 0;
         if (p.data_pins_oe && rd) viol++;
         if (p.data_pins_oe) begin
            lvl = p.data_pins_out;
            valid = 1'b0;
         end else if (rd && ans >= ACCESS_NS) begin
            lvl = mem[p.word_address];
            valid = 1'b1;
         end else if (!(valid && ans < 15)) begin
            // undriven pins toggle so a stale value never looks valid
            lvl = ~lvl;
            valid = 1'b0;
         end
         la = p.word_address;
         ld = p.data_pins_out;
         lrd = rd;
         wact = wr;
         #1;
      end
   end
endmodule

// [tb.sv]
`timescale 1ns/1ps
`include "sram_host_map.svh"
module tb;
   import sram_host_pkg::*;
   localparam int REC = 20;
   logic        core_clk, reset, req_valid, retention_req;
   logic        req_ready, rdata_valid, write_done;
   logic [8:0]  rdata, lvl;
   req_s        req;
   pins_s       pins;
   int          viol, fail_count, check_count, k;
   integer      seed;
   logic [8:0]  mem [131072];
   logic [16:0] addrs [$];
   logic [16:0] a;

   sram_host #(.RECOVERY_CYCLES(REC)) i_sram_host (.core_clk(core_clk), .reset(reset),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rdata(rdata),
      .rdata_valid(rdata_valid), .write_done(write_done), .retention_req(retention_req),
      .sram_pins(pins), .data_pins_in(lvl));
   sram_model #(.ACCESS_NS(`T_AA_NS)) i_sram_model (.p(pins), .lvl(lvl), .viol(viol));

   // ****************************************************
   // checks and waits
   // ****************************************************
   task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
      check_count++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   function automatic logic [8:0] exp_rd(input logic [16:0] ad);
      return mem[ad];
   endfunction

   task automatic final_report();
      $display("checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // levels are seen as they stood just before each rising edge
   // which: 0 ready, 1 write done, 2 read valid
   task automatic wait_hi(input string what, input int which, input int lim);
      int   n;
      logic s;
      n = 0;
      s = 1'b0;
      do begin
         @(posedge core_clk);
         n++;
         s = (which == 0) ? req_ready : (which == 1) ? write_done : rdata_valid;
      end while (s !== 1'b1 && n < lim);
      chk(what, 17'h1, {16'h0, s});
      if (s !== 1'b1) final_report();
   endtask

   task automatic access(input logic w, input logic [16:0] ad, input logic [8:0] dt);
      req_valid <= 1'b1;
      req <= {w, ad, dt};
      wait_hi("req_ready", 0, 400);
      req_valid <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("req_ready busy", 17'h0, {16'h0, req_ready});
      if (w) begin
         wait_hi("write_done", 1, 12);
         mem[ad] = dt;
         addrs.push_back(ad);
      end else begin
         wait_hi("rdata_valid", 2, 12);
         chk("rdata", {8'h0, exp_rd(ad)}, {8'h0, rdata});
      end
   endtask

   // ****************************************************
   // clock, watchdog and main sequence
   // ****************************************************
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      chk("run length", 17'h0, 17'h1);
      final_report();
   end

   initial begin
      seed = 32'h606e8d0e;
      {fail_count, check_count} = '0;
      {reset, req_valid, retention_req, req} = {3'b100, 27'h0};
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      chk("pins in reset", 17'h16, {12'h0, pins.chip_select_active_low,
          pins.chip_select_active_high, pins.output_enable_n, pins.write_enable_n,
          pins.data_pins_oe});
      access(1'b1, 17'h00000, 9'h1ff);
      access(1'b1, 17'h1ffff, 9'h000);
      access(1'b0, 17'h00000, 9'h000);
      access(1'b0, 17'h1ffff, 9'h000);
      access(1'b1, 17'h00000, 9'h0aa);
      access(1'b0, 17'h00000, 9'h000);
      // random mix; reads only hit written words since fresh cells are unknown
      for (k = 0; k < 60; k++) begin
         a = 17'($random(seed));
         if ($random(seed) & 1)
            access(1'b1, a, 9'($random(seed)));
         else
            access(1'b0, addrs[$unsigned($random(seed)) % addrs.size()], 9'h0);
      end
      retention_req <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("parked selects", 17'h2, {15'h0, pins.chip_select_active_low,
          pins.chip_select_active_high});
      chk("req_ready parked", 17'h0, {16'h0, req_ready});
      retention_req <= 1'b0;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (req_ready !== 1'b1 && k < 100);
      chk("recovery wait", 17'h1, {16'h0, k >= REC && k <= REC + 4});
      if (req_ready !== 1'b1) final_report();
      access(1'b0, 17'h1ffff, 9'h000);
      chk("host violations", 17'h0, 17'(viol));
      final_report();
   end
endmodule
